// ### rtl/line_trigger_exposure_control.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module line_trigger_exposure_control #(
	parameter int BLINK_HALF_CYCLES = line_trig_pkg::BLINK_HALF_CYCLES,
	parameter int FILTER_CYCLES     = line_trig_pkg::FILTER_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               reset,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic      [31:0]        reg_rdata,
	input  wire logic               boot_done,
	input  wire logic               link_up,
	input  wire logic               discovery_active,
	input  wire logic               discovery_done,
	input  wire logic               packets_sending,
	input  wire logic               encoder_unit_output,
	input  wire logic               ext_input_a,
	input  wire logic               ext_input_b,
	input  wire logic               ext_input_c,
	output line_trig_pkg::led_s     status_led,
	output line_trig_pkg::window_s  window,
	output logic                    frame_gate,
	output logic                    line_exposure_trigger,
	output logic                    filler_frame_emit,
	output logic                    exposure_active
);
	import line_trig_pkg::*;

	localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
	localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);

	// tenths of a microsecond to cycles, rounded up
	function automatic logic [19:0] tenths_to_cycles(input logic [15:0] t);
		logic [23:0] prod;
		prod = 24'(t) * 24'(CLK_MHZ) + 24'(TENTHS_PER_US - 1);
		return 20'(prod / 24'(TENTHS_PER_US));
	endfunction

	// true when a pixel count sits on a four pixel step
	function automatic logic step_of_four(input logic [12:0] v);
		return v[1:0] == 2'b00;
	endfunction

	trig_cfg_s   cfg_q;                 // trigger configuration
	logic [15:0] exposure_q;            // exposure in tenths of a microsecond
	logic [31:0] user_id_q [USER_ID_WORDS]; // identification string words
	logic        ctrl_open_q;           // discovery completed on the current link
	led_state_e  led_state_q;           // indicator state
	logic [BW-1:0] blink_cnt_q;         // blink half period counter
	logic        blink_q;               // blink phase
	logic [2:0]  line_clean;            // filtered line inputs
	logic        src_level;             // chosen trigger source level
	logic        src_prev_q;            // source level last cycle
	logic        active_prev_q;         // sensed activity last cycle
	logic        sense_active;          // source level in its active sense
	logic        trig_event;            // one-cycle trigger event
	logic [19:0] exp_cnt_q;             // exposure cycles remaining
	logic        wr_ctrl;               // any register write while control access is open
	logic [12:0] wr_val;                // write data as a pixel count

	assign wr_val  = reg_wdata[12:0];
	assign wr_ctrl = reg_write && ctrl_open_q;

	// control access opens once discovery has completed
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_open_q <= 1'b0;
		end else if (discovery_done && link_up) begin
			ctrl_open_q <= 1'b1;
		end else if (!link_up) begin
			ctrl_open_q <= 1'b0; // cable pulled, host must rediscover
		end
	end

	// trigger configuration register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= '{external_trigger_enable: 1'b0,
			           trigger_function_select: FUNC_FRAME_GATE,
			           trigger_origin_select:   ORIGIN_NO_SOURCE,
			           trigger_sense_select:    SENSE_RISING,
			           exposure_control_mode:   EXP_TIMED,
			           line_invert:             3'h0};
		end else if (wr_ctrl && reg_addr == ADDR_CTRL) begin
			cfg_q.external_trigger_enable <= reg_wdata[CTRL_ENABLE_BIT];
			// illegal codes leave the old selection in place
			if (reg_wdata[CTRL_FUNC_LSB +: 2] <= 2'(FUNC_FILLER_FRAME)) begin
				cfg_q.trigger_function_select <= trig_func_e'(reg_wdata[CTRL_FUNC_LSB +: 2]);
			end
			if (reg_wdata[CTRL_ORIGIN_LSB +: 3] <= 3'(ORIGIN_EXT_C)) begin
				cfg_q.trigger_origin_select <= trig_origin_e'(reg_wdata[CTRL_ORIGIN_LSB +: 3]);
			end
			if (reg_wdata[CTRL_SENSE_LSB +: 3] <= 3'(SENSE_LOW)) begin
				cfg_q.trigger_sense_select <= trig_sense_e'(reg_wdata[CTRL_SENSE_LSB +: 3]);
			end
			cfg_q.exposure_control_mode <= exp_mode_e'(reg_wdata[CTRL_EXPMODE_BIT]);
			cfg_q.line_invert           <= reg_wdata[CTRL_INVERT_LSB +: 3];
		end
	end

	// image window registers, bad values and overruns are rejected
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			window.line_width              <= WIDTH_RESET;
			window.horizontal_start_offset <= OFFSET_RESET;
			window.frame_height            <= HEIGHT_RESET;
		end else if (wr_ctrl) begin
			unique case (reg_addr)
				ADDR_WIDTH: begin
					// width must fit beside the current offset
					if (reg_wdata[31:13] == '0 && wr_val >= WIDTH_MIN && step_of_four(wr_val)
					    && 14'(wr_val) + 14'(window.horizontal_start_offset)
					       <= 14'(SENSOR_LINE_LEN)) begin
						window.line_width <= wr_val;
					end
				end
				ADDR_OFFSET: begin
					// offset must fit beside the current width
					if (reg_wdata[31:13] == '0 && wr_val <= OFFSET_MAX && step_of_four(wr_val)
					    && 14'(wr_val) + 14'(window.line_width)
					       <= 14'(SENSOR_LINE_LEN)) begin
						window.horizontal_start_offset <= wr_val;
					end
				end
				ADDR_HEIGHT: begin
					if (reg_wdata[31:13] == '0 && wr_val >= HEIGHT_MIN
					    && wr_val <= HEIGHT_MAX) begin
						window.frame_height <= wr_val;
					end
				end
				default: begin
					// other addresses leave the window alone
				end
			endcase
		end
	end

	// exposure time register in tenths of a microsecond
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			exposure_q <= EXPOSURE_RESET;
		end else if (wr_ctrl && reg_addr == ADDR_EXPOSURE) begin
			if (reg_wdata[31:16] == '0 && reg_wdata[15:0] >= EXPOSURE_MIN
			    && reg_wdata[15:0] <= EXPOSURE_MAX) begin
				exposure_q <= reg_wdata[15:0];
			end
		end
	end

	// identification string, last byte always the terminator
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < USER_ID_WORDS; i++) user_id_q[i] <= '0;
		end else if (wr_ctrl && reg_addr[7:4] == ADDR_USER_ID[7:4]) begin
			if (reg_addr[3:2] == 2'(USER_ID_WORDS - 1)) begin
				user_id_q[reg_addr[3:2]] <= {8'h00, reg_wdata[23:0]};
			end else begin
				user_id_q[reg_addr[3:2]] <= reg_wdata;
			end
		end
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= '0; // unmapped reads give zero
			if (reg_addr == ADDR_CTRL) begin
				reg_rdata[CTRL_ENABLE_BIT]       <= cfg_q.external_trigger_enable;
				reg_rdata[CTRL_FUNC_LSB +: 2]    <= cfg_q.trigger_function_select;
				reg_rdata[CTRL_ORIGIN_LSB +: 3]  <= cfg_q.trigger_origin_select;
				reg_rdata[CTRL_SENSE_LSB +: 3]   <= cfg_q.trigger_sense_select;
				reg_rdata[CTRL_EXPMODE_BIT]      <= cfg_q.exposure_control_mode;
				reg_rdata[CTRL_INVERT_LSB +: 3]  <= cfg_q.line_invert;
			end else if (reg_addr == ADDR_WIDTH) begin
				reg_rdata[12:0] <= window.line_width;
			end else if (reg_addr == ADDR_OFFSET) begin
				reg_rdata[12:0] <= window.horizontal_start_offset;
			end else if (reg_addr == ADDR_HEIGHT) begin
				reg_rdata[12:0] <= window.frame_height;
			end else if (reg_addr == ADDR_EXPOSURE) begin
				reg_rdata[15:0] <= exposure_q;
			end else if (reg_addr == ADDR_STATUS) begin
				// live state of the block
				reg_rdata[2:0] <= led_state_q;
				reg_rdata[3]   <= ctrl_open_q;
				reg_rdata[4]   <= exposure_active;
				reg_rdata[7:5] <= line_clean;
			end else if (reg_addr[7:4] == ADDR_USER_ID[7:4]) begin
				reg_rdata <= user_id_q[reg_addr[3:2]];
			end
		end
	end

	// status indicator state machine
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			led_state_q <= LED_BOOT;
		end else if (!boot_done) begin
			led_state_q <= LED_BOOT;
		end else if (!link_up) begin
			led_state_q <= LED_NO_CABLE;
		end else if (!ctrl_open_q || discovery_active) begin
			led_state_q <= LED_DISCOVERY;
		end else if (packets_sending) begin
			led_state_q <= LED_STREAMING;
		end else begin
			led_state_q <= LED_STANDBY;
		end
	end

	// blink phase generator
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= BLINK_LAST) begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end

	// indicator colour, orange is red plus green, dark in reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			status_led <= '0;
		end else begin
			unique case (led_state_q)
				LED_BOOT:      status_led <= '{red: 1'b1, green: 1'b1};
				LED_NO_CABLE:  status_led <= '{red: 1'b1, green: 1'b0};
				LED_DISCOVERY: status_led <= '{red: blink_q, green: blink_q};
				LED_STANDBY:   status_led <= '{red: 1'b0, green: 1'b1};
				LED_STREAMING: status_led <= '{red: 1'b0, green: blink_q};
			endcase
		end
	end

	// line inputs: synchronise, invert and filter
	line_input_conditioner #(
		.LANES         (3),
		.FILTER_CYCLES (FILTER_CYCLES)
	) u_cond (
		.core_clk  (core_clk),
		.reset     (reset),
		.pin_in    ({ext_input_c, ext_input_b, ext_input_a}),
		.invert    (cfg_q.line_invert),
		.clean_out (line_clean)
	);

	// source multiplexer
	always_comb begin
		unique case (cfg_q.trigger_origin_select)
			ORIGIN_NO_SOURCE: src_level = 1'b0;
			ORIGIN_ENCODER:   src_level = encoder_unit_output;
			ORIGIN_EXT_A:     src_level = line_clean[0];
			ORIGIN_EXT_B:     src_level = line_clean[1];
			ORIGIN_EXT_C:     src_level = line_clean[2];
			default:          src_level = 1'b0;
		endcase
	end

	// sense decode: edges give events, levels give an active span
	always_comb begin
		sense_active = 1'b0;
		trig_event   = 1'b0;
		unique case (cfg_q.trigger_sense_select)
			SENSE_RISING:   trig_event = src_level && !src_prev_q;
			SENSE_FALLING:  trig_event = !src_level && src_prev_q;
			SENSE_ANY_EDGE: trig_event = src_level ^ src_prev_q;
			SENSE_HIGH: begin
				sense_active = src_level;
				trig_event   = src_level && !active_prev_q;
			end
			SENSE_LOW: begin
				sense_active = !src_level;
				trig_event   = !src_level && !active_prev_q;
			end
			default: begin
				sense_active = 1'b0;
				trig_event   = 1'b0;
			end
		endcase
		trig_event = trig_event && cfg_q.external_trigger_enable;
	end

	// source history for edge detection
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			src_prev_q    <= 1'b0;
			active_prev_q <= 1'b0;
		end else begin
			src_prev_q    <= src_level;
			active_prev_q <= sense_active;
		end
	end

	// trigger function outputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			frame_gate            <= 1'b0;
			line_exposure_trigger <= 1'b0;
			filler_frame_emit     <= 1'b0;
		end else begin
			line_exposure_trigger <= trig_event
				&& cfg_q.trigger_function_select == FUNC_LINE_EXPOSURE;
			filler_frame_emit     <= trig_event
				&& cfg_q.trigger_function_select == FUNC_FILLER_FRAME;
			if (!cfg_q.external_trigger_enable
			    || cfg_q.trigger_function_select != FUNC_FRAME_GATE) begin
				frame_gate <= 1'b0;
			end else if (cfg_q.trigger_sense_select == SENSE_HIGH
			             || cfg_q.trigger_sense_select == SENSE_LOW) begin
				frame_gate <= sense_active;
			end else if (trig_event) begin
				frame_gate <= ~frame_gate; // edges open and close the gate
			end
		end
	end

	// exposure timer: timed count or trigger high width
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			exp_cnt_q       <= '0;
			exposure_active <= 1'b0;
		end else if (!exposure_active) begin
			if (trig_event && cfg_q.trigger_function_select == FUNC_LINE_EXPOSURE) begin
				exposure_active <= 1'b1;
				exp_cnt_q       <= tenths_to_cycles(exposure_q) - 20'h00001;
			end
		end else if (cfg_q.exposure_control_mode == EXP_PULSE_LENGTH) begin
			if (!src_level) begin
				exposure_active <= 1'b0;
			end
		end else if (exp_cnt_q == '0) begin
			exposure_active <= 1'b0;
		end else begin
			exp_cnt_q <= exp_cnt_q - 20'h00001;
		end
	end

endmodule

// ### rtl/line_trig_pkg.sv
package line_trig_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_WIDTH    = 8'h04;
	localparam logic [7:0] ADDR_OFFSET   = 8'h08;
	localparam logic [7:0] ADDR_HEIGHT   = 8'h0c;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_USER_ID  = 8'h20;
	localparam int         USER_ID_WORDS = 4;

	// control register field positions
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_FUNC_LSB    = 1;
	localparam int CTRL_ORIGIN_LSB  = 3;
	localparam int CTRL_SENSE_LSB   = 6;
	localparam int CTRL_EXPMODE_BIT = 9;
	localparam int CTRL_INVERT_LSB  = 10;

	// image window limits and reset values
	localparam logic [12:0] SENSOR_LINE_LEN = 13'h1800;
	localparam logic [12:0] WIDTH_MIN       = 13'h0004;
	localparam logic [12:0] WIDTH_RESET     = 13'h1800;
	localparam logic [12:0] OFFSET_MAX      = 13'h17fc;
	localparam logic [12:0] OFFSET_RESET    = 13'h0000;
	localparam logic [12:0] HEIGHT_MIN      = 13'h0010;
	localparam logic [12:0] HEIGHT_MAX      = 13'h1000;
	localparam logic [12:0] HEIGHT_RESET    = 13'h0800;

	// exposure in tenths of a microsecond
	localparam logic [15:0] EXPOSURE_MIN    = 16'h0014;
	localparam logic [15:0] EXPOSURE_MAX    = 16'h821e;
	localparam logic [15:0] EXPOSURE_RESET  = 16'h04b0;
	localparam int          CLK_MHZ         = 125;
	localparam int          TENTHS_PER_US   = 10;

	// led blink half period and chatter filter defaults
	localparam int BLINK_HALF_MS     = 250;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int FILTER_US         = 10;
	localparam int FILTER_CYCLES     = FILTER_US * CLK_MHZ;

	// status indicator states
	typedef enum logic [2:0] {
		LED_BOOT, LED_NO_CABLE, LED_DISCOVERY, LED_STANDBY, LED_STREAMING
	} led_state_e;

	// what the trigger drives
	typedef enum logic [1:0] {
		FUNC_FRAME_GATE, FUNC_LINE_EXPOSURE, FUNC_FILLER_FRAME
	} trig_func_e;

	// where the trigger comes from
	typedef enum logic [2:0] {
		ORIGIN_NO_SOURCE, ORIGIN_ENCODER, ORIGIN_EXT_A, ORIGIN_EXT_B, ORIGIN_EXT_C
	} trig_origin_e;

	// how the trigger is sensed
	typedef enum logic [2:0] {
		SENSE_RISING, SENSE_FALLING, SENSE_ANY_EDGE, SENSE_HIGH, SENSE_LOW
	} trig_sense_e;

	// how long an exposure lasts
	typedef enum logic {
		EXP_TIMED, EXP_PULSE_LENGTH
	} exp_mode_e;

	// trigger configuration carried together
	typedef struct packed {
		logic         external_trigger_enable;
		trig_func_e   trigger_function_select;
		trig_origin_e trigger_origin_select;
		trig_sense_e  trigger_sense_select;
		exp_mode_e    exposure_control_mode;
		logic [2:0]   line_invert;
	} trig_cfg_s;

	// image window carried together
	typedef struct packed {
		logic [12:0] line_width;
		logic [12:0] horizontal_start_offset;
		logic [12:0] frame_height;
	} window_s;

	// status indicator colour pair
	typedef struct packed {
		logic red;
		logic green;
	} led_s;

endpackage

// ### rtl/line_input_conditioner.sv
`timescale 1ns/10ps
module line_input_conditioner #(
	parameter int LANES         = 3,
	parameter int FILTER_CYCLES = line_trig_pkg::FILTER_CYCLES
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [LANES-1:0] pin_in,
	input  wire logic [LANES-1:0] invert,
	output logic      [LANES-1:0] clean_out
);
	import line_trig_pkg::*;

	localparam int CW = $clog2(FILTER_CYCLES + 1);
	localparam logic [CW-1:0] FILT_LAST = CW'(FILTER_CYCLES - 1);

	logic [LANES-1:0] sync1_q;           // first synchroniser stage
	logic [LANES-1:0] sync2_q;           // second synchroniser stage
	logic [CW-1:0]    stable_q [LANES];  // cycles the raw level has differed

	// two-flop synchroniser for the pin levels
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// chatter filter: new level must hold for the filter time
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			clean_out <= '0;
			for (int i = 0; i < LANES; i++) stable_q[i] <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				if ((sync2_q[i] ^ invert[i]) == clean_out[i]) begin
					stable_q[i] <= '0; // level agrees, restart
				end else if (stable_q[i] >= FILT_LAST) begin
					clean_out[i] <= sync2_q[i] ^ invert[i];
					stable_q[i]  <= '0;
				end else begin
					stable_q[i] <= stable_q[i] + 1'b1;
				end
			end
		end
	end

endmodule

// ### testbench/line_trig_asserts.sv
`timescale 1ns/10ps
// port-side checks of the trigger and window block
module line_trig_asserts (
	input wire logic                   core_clk,
	input wire logic                   reset,
	input wire logic [7:0]             reg_addr,
	input wire logic                   reg_read,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   boot_done,
	input wire logic                   link_up,
	input wire line_trig_pkg::led_s    status_led,
	input wire line_trig_pkg::window_s window,
	input wire logic                   line_exposure_trigger,
	input wire logic                   filler_frame_emit,
	input wire logic                   exposure_active
);
	import line_trig_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// window leaves reset at its defaults
	win_reset_a: assert property (
		$fell(reset) |-> window == {WIDTH_RESET, OFFSET_RESET, HEIGHT_RESET})
		else $error("window not at defaults after reset");
	// width stays in range and on a step of four
	width_legal_a: assert property (
		window.line_width >= WIDTH_MIN && window.line_width <= 13'h1800
		&& window.line_width[1:0] == 2'h0) else $error("line width illegal");
	// offset stays in range and on a step of four
	offset_legal_a: assert property (
		window.horizontal_start_offset <= OFFSET_MAX
		&& window.horizontal_start_offset[1:0] == 2'h0) else $error("offset illegal");
	// height stays in range
	height_legal_a: assert property (
		window.frame_height >= HEIGHT_MIN && window.frame_height <= HEIGHT_MAX)
		else $error("frame height illegal");
	// offset plus width never passes the sensor line
	window_fit_a: assert property (
		{1'b0, window.line_width} + {1'b0, window.horizontal_start_offset} <= 14'h1800)
		else $error("window exceeds sensor line");
	// orange while booting
	boot_orange_a: assert property (
		!boot_done [*3] |-> status_led == 2'b11) else $error("boot colour wrong");
	// red whenever the cable is out after boot
	cable_red_a: assert property (
		(boot_done && !link_up) [*4] |-> status_led == 2'b10) else $error("no red");
	// a line trigger opens a fresh exposure in the same cycle
	exp_start_a: assert property (
		line_exposure_trigger |-> exposure_active && !$past(exposure_active))
		else $error("exposure did not start with trigger");
	// filler frame request is a single pulse
	filler_pulse_a: assert property (
		filler_frame_emit |=> !filler_frame_emit) else $error("filler pulse too long");
	// last id byte is the null terminator
	id_null_a: assert property (
		reg_read && reg_addr == 8'h2c |=> reg_rdata[31:24] == 8'h00)
		else $error("id terminator not null");
endmodule

bind line_trigger_exposure_control line_trig_asserts i_line_trig_asserts (
	.core_clk, .reset, .reg_addr, .reg_read, .reg_rdata, .boot_done, .link_up,
	.status_led, .window, .line_exposure_trigger, .filler_frame_emit, .exposure_active
);

// ### testbench/trig_source_model.sv
`timescale 1ns/10ps
// far side: three trigger lines and the encoder
module trig_source_model (
	input  wire logic       core_clk,
	output logic      [2:0] ext_pins,
	output logic            enc
);
	// lines are actively driven low when idle
	initial begin
		ext_pins = 3'h0;
		enc      = 1'b0;
	end
	// one line high for hi cycles; width mode exposes for exactly this
	task automatic pulse(int lane, int hi);
		@(posedge core_clk);
		ext_pins[lane] <= 1'b1;
		repeat (hi) @(posedge core_clk);
		ext_pins[lane] <= 1'b0;
	endtask
	// encoder shares the clock, so it moves on an edge
	task automatic enc_set(logic v);
		@(posedge core_clk);
		enc <= v;
	endtask
endmodule

// ### testbench/line_trigger_exposure_control_tb.sv
`timescale 1ns/10ps
module line_trigger_exposure_control_tb;
	import line_trig_pkg::*;
	logic        core_clk, reset, reg_write, reg_read, boot_done, link_up;
	logic        discovery_active, discovery_done, packets_sending;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0]  ext_pins;
	logic        enc, frame_gate, line_pulse, filler_pulse, exp_on;
	led_s        status_led;
	window_s     window;
	int          num_errors, tests_run, cyc, nl, nf, ne, a, d;
	int          m[int];                      // register model
	bit          ctl_open;                    // model of the control gate
	int          ra[10] = '{0, 4, 8, 'hc, 'h10, 'h18, 'h20, 'h24, 'h28, 'h2c};
	int          ta[13] = '{4, 4, 4, 8, 4, 8, 'hc, 'hc, 'hc, 'h10, 'h10, 'h10, 4};
	int          td[13] = '{'h100, 'h101, 0, 'h1700, 'h200, 'h17fd, 'hf, 'h1000,
		'h1001, 'h13, 'h821e, 'h821f, 'h10000100};
	int          sev[5] = '{1, 1, 2, 1, 1};  // events per sense for one high span

	// free running clock, 8 ns
	always #4 core_clk = ~core_clk;

	line_trigger_exposure_control #(.BLINK_HALF_CYCLES(4), .FILTER_CYCLES(2))
	i_line_trigger_exposure_control (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.boot_done(boot_done), .link_up(link_up), .discovery_active(discovery_active),
		.discovery_done(discovery_done), .packets_sending(packets_sending),
		.encoder_unit_output(enc), .ext_input_a(ext_pins[0]), .ext_input_b(ext_pins[1]),
		.ext_input_c(ext_pins[2]), .status_led(status_led), .window(window),
		.frame_gate(frame_gate), .line_exposure_trigger(line_pulse),
		.filler_frame_emit(filler_pulse), .exposure_active(exp_on));

	trig_source_model i_trig_source_model (
		.core_clk(core_clk), .ext_pins(ext_pins), .enc(enc));

	// pulse counters and the hang limit
	always @(posedge core_clk) begin
		cyc++;
		if (line_pulse === 1'b1) nl++;
		if (filler_pulse === 1'b1) nf++;
		if (exp_on === 1'b1) ne++;
		if (cyc == 60000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// acceptance of a write, from the ranges and steps
	function automatic bit legal(int ad, longint v);
		case (ad)
			'h04: return v >= 4 && v <= 6144 && v % 4 == 0 && v + m['h08] <= 6144;
			'h08: return v <= 6140 && v % 4 == 0 && v + m['h04] <= 6144;
			'h0c: return v >= 16 && v <= 4096;
			'h10: return v >= 20 && v <= 33310;
			'h00, 'h20, 'h24, 'h28, 'h2c: return 1;
			default: return 0;
		endcase
	endfunction

	// one write cycle, model follows only when open and legal
	task automatic wr(logic [7:0] ad, logic [31:0] v);
		@(posedge core_clk);
		reg_addr  <= ad;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		if (ctl_open && legal(ad, {32'h0, v})) m[ad] = (ad == 8'h2c) ? v & 'hffffff : v;
	endtask

	// one read cycle, data taken in the following cycle
	task automatic rd(logic [7:0] ad);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, m[ad]);
	endtask

	// steady or blinking colour over six half periods
	task automatic led(logic [1:0] on, bit blink);
		int n1, n0;
		n1 = 0;
		n0 = 0;
		repeat (24) begin
			@(posedge core_clk);
			#1;
			if (status_led === on) n1++;
			else if (status_led === 2'b00) n0++;
		end
		chk(blink ? (n1 > 0 && n0 > 0 && n1 + n0 == 24) : n1 == 24, 1);
	endtask

	function automatic logic [31:0] ctl(int f, int o, int s, int x);
		return 32'(1 + f * 2 + o * 8 + s * 64 + x * 512);
	endfunction

	// encoder high then low, counting trigger outputs
	task automatic enc_run(logic [31:0] c, int el, int ef);
		wr(8'h00, c);
		repeat (300) @(posedge core_clk);
		nl = 0;
		nf = 0;
		i_trig_source_model.enc_set(1'b1);
		repeat (300) @(posedge core_clk);
		i_trig_source_model.enc_set(1'b0);
		repeat (300) @(posedge core_clk);
		chk(32'(nl), 32'(el));
		chk(32'(nf), 32'(ef));
	endtask

	// main sequence
	initial begin
		core_clk = 0;
		reset = 1;
		{reg_write, reg_read, boot_done, link_up, discovery_active} = 5'h0;
		{discovery_done, packets_sending, reg_addr, reg_wdata} = '0;
		m = '{0: 0, 4: 6144, 8: 0, 'hc: 2048, 'h10: 1200, 'h18: 0, 'h20: 0, 'h24: 0,
			'h28: 0, 'h2c: 0};
		void'($urandom(32));
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		led(2'b11, 0);
		foreach (ra[i]) rd(8'(ra[i]));
		boot_done <= 1'b1;
		repeat (4) @(posedge core_clk);
		led(2'b10, 0);
		link_up          <= 1'b1;
		discovery_active <= 1'b1;
		repeat (3) @(posedge core_clk);
		led(2'b11, 1);
		wr(8'h04, 32'h100);
		rd(8'h04);
		discovery_active <= 1'b0;
		discovery_done   <= 1'b1;
		repeat (4) @(posedge core_clk);
		ctl_open = 1;
		led(2'b01, 0);
		packets_sending <= 1'b1;
		repeat (3) @(posedge core_clk);
		led(2'b01, 1);
		packets_sending <= 1'b0;
		foreach (ta[i]) begin
			wr(8'(ta[i]), 32'(td[i]));
			rd(8'(ta[i]));
		end
		repeat (24) begin
			a = 4 + 4 * ($urandom % 3);
			d = ($urandom % 1800) * 4 + 32'($urandom % 8 == 0);
			wr(8'(a), 32'(d));
			rd(8'(a));
			@(posedge core_clk);
			{discovery_active, packets_sending} <= 2'($urandom);
			repeat (3) @(posedge core_clk);
			if (discovery_active) d = status_led[1] == status_led[0];
			else if (packets_sending) d = !status_led[1];
			else d = status_led == 2'b01;
			chk(32'(d), 1);
		end
		{discovery_active, packets_sending} <= 2'h0;
		for (int i = 'h20; i <= 'h2c; i += 4) begin
			wr(8'(i), $urandom);
			rd(8'(i));
		end
		wr(8'h10, 32'd20);
		for (int s = 0; s < 5; s++) enc_run(ctl(1, 1, s, 0), sev[s], 0);
		enc_run(ctl(2, 1, 0, 0), 0, 1);
		enc_run(ctl(1, 1, 0, 0) & ~32'h1, 0, 0);
		wr(8'h00, ctl(0, 1, 3, 0));
		i_trig_source_model.enc_set(1'b1);
		repeat (5) @(posedge core_clk);
		chk(frame_gate, 1);
		i_trig_source_model.enc_set(1'b0);
		repeat (5) @(posedge core_clk);
		chk(frame_gate, 0);
		wr(8'h00, ctl(1, 2, 1, 0) | 32'h400);
		repeat (10) @(posedge core_clk);
		{nl, ne} = 0;
		i_trig_source_model.pulse(0, 20);
		repeat (400) @(posedge core_clk);
		chk(32'(ne), 32'd250);
		chk(32'(nl), 32'd1);
		wr(8'h00, ctl(1, 4, 3, 1));
		repeat (10) @(posedge core_clk);
		ne = 0;
		i_trig_source_model.pulse(2, 40);
		repeat (60) @(posedge core_clk);
		chk(ne >= 39 && ne <= 41, 1);
		wr(8'h00, ctl(1, 3, 0, 0));
		repeat (10) @(posedge core_clk);
		nl = 0;
		i_trig_source_model.pulse(1, 10);
		repeat (300) @(posedge core_clk);
		chk(32'(nl), 32'd1);
		link_up  <= 1'b0;
		ctl_open = 0;
		repeat (4) @(posedge core_clk);
		led(2'b10, 0);
		wr(8'h0c, 32'd16);
		rd(8'h0c);
		finish_test();
	end
endmodule
